// file: rtl/segmented_adc_capture_format.sv
// Behaviour
// - Sample is 12-bit two's complement in 16 bits
// - Bytes leave upper byte first, lower second
// - Unrouted top bits copy converter bit 11
// - Converter bits 11..0 map straight to 11..0
// - Lines 3..0 land in bits 15..12
// - One segment per trigger, no restart
// - Memory split into equal segments, filled in turn
// - Trigger re-armed by hardware after fixed interval
// - Post count sets samples after trigger
// - Segment length sets total samples per trigger
// - Pre count is segment length minus post
// - Pre count above channel cap is an error
// - Mode value 2 selects memory segmented recording
// - Total count bounds memory mode, multiple of segment
// - Mode value 32 selects streaming segmented recording
// - Streaming runs until stopped, only segments sent
// - Segment count stops streaming, zero means endless
// - Per-channel routing picks line per top bit
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "seg_capture_defines.svh"
module segmented_adc_capture_format (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic adc_valid,
  input wire logic [11:0] adc_ch0,
  input wire logic [11:0] adc_ch1,
  input wire logic [3:0] mpio_in,
  input wire logic trig_in,
  output logic out_valid,
  output logic [7:0] out_byte,
  input wire logic out_ready,
  output logic busy
);
  import seg_capture_pkg::*;

  // ----------------------------------------------------------------------
  // Sample formatting
  // ----------------------------------------------------------------------
  // Each top bit takes a routed line or a copy of the sign bit
  function automatic seg_capture_pkg::sample_word_t fmt_word(
    input logic [11:0] adc, input logic [3:0] lines, input logic [31:0] route);
    seg_capture_pkg::sample_word_t w;
    logic [`ROUTE_FLD_W-1:0] fld;
    w = {{4{adc[`SIGN_BIT]}}, adc};
    for (int k = 0; k < 4; k++) begin
      fld = route[`ROUTE_LSB0 + `ROUTE_FLD_W*k +: `ROUTE_FLD_W];
      if (fld[4:2] == `ROUTE_SRC_TAG) begin
        w[`ROUTE_LSB0 + k] = lines[fld[1:0]];
      end
    end
    return w;
  endfunction : fmt_word

  logic [31:0] mode_reg, mode_next, loops_reg, loops_next;
  logic [63:0] total_reg, total_next, seglen_reg, seglen_next, post_reg, post_next;
  logic [31:0] route0_reg, route0_next, route1_reg, route1_next;
  logic [1:0] chen_reg, chen_next;
  logic [31:0] prdata_reg, prdata_next, rd_mux;
  logic [15:0] idx;
  logic hit, wr_acc, wr_ctrl, start_req, stop_req;
  cap_state_e cap_state, cap_state_next;
  rd_state_e rd_state, rd_state_next;
  logic [`MEM_AW-1:0] base_reg, base_next;
  logic [31:0] wofs_reg, wofs_next, pre_fill_reg, pre_fill_next;
  logic [31:0] post_cnt_reg, post_cnt_next, seg_cnt_reg, seg_cnt_next;
  logic [3:0] rearm_reg, rearm_next;
  logic pre_err_reg, pre_err_next, ovf_reg, ovf_next;
  logic [31:0] seglen, post, pre_len, cap_max, wofs_inc;
  logic cfg_err, stream_mode, mem_mode, seg_done, last_seg, mem_we;
  logic [`MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [31:0] mem_wdata, rd_data_reg;
  logic [31:0] mem [0:`MEM_WORDS-1];
  seg_capture_pkg::sample_word_t fmt0, fmt1;
  logic pend_reg, pend_next, take;
  logic [`MEM_AW-1:0] pend_base_reg, pend_base_next, rd_base_reg, rd_base_next;
  logic [31:0] pend_start_reg, pend_start_next, rd_ofs_reg, rd_ofs_next;
  logic [31:0] rd_left_reg, rd_left_next;
  logic [1:0] phase_reg, phase_next, first_phase;
  logic out_valid_reg, out_valid_next, last_phase;
  logic [7:0] out_byte_reg, out_byte_next;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Decode; always ready, unmapped addresses answer with pslverr
  assign idx = paddr[17:2];
  assign hit = (idx == `IDX_CTRL) || (idx == `IDX_STATUS) || (idx == `IDX_SEG_DONE) ||
               (idx == `IDX_MODE) || (idx == `IDX_TOTAL) || (idx == `IDX_TOTAL + 16'h0001) ||
               (idx == `IDX_SEGLEN) || (idx == `IDX_SEGLEN + 16'h0001) ||
               (idx == `IDX_LOOPS) || (idx == `IDX_POST) || (idx == `IDX_POST + 16'h0001) ||
               (idx == `IDX_ROUTE0) || (idx == `IDX_ROUTE1);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;
  assign wr_acc = psel && penable && pwrite && hit;
  assign wr_ctrl = wr_acc && (idx == `IDX_CTRL);
  assign start_req = wr_ctrl && pwdata[`CTRL_START];
  assign stop_req = wr_ctrl && pwdata[`CTRL_STOP];

  // Read mux; status shows both sequencers and sticky errors
  always_comb begin
    case (idx)
      `IDX_CTRL: rd_mux = {26'h000_0000, chen_reg, 4'h0};
      `IDX_STATUS: rd_mux = {22'h00_0000, ovf_reg, pre_err_reg, rd_state, cap_state};
      `IDX_SEG_DONE: rd_mux = seg_cnt_reg;
      `IDX_MODE: rd_mux = mode_reg;
      `IDX_TOTAL: rd_mux = total_reg[31:0];
      `IDX_TOTAL + 16'h0001: rd_mux = total_reg[63:32];
      `IDX_SEGLEN: rd_mux = seglen_reg[31:0];
      `IDX_SEGLEN + 16'h0001: rd_mux = seglen_reg[63:32];
      `IDX_LOOPS: rd_mux = loops_reg;
      `IDX_POST: rd_mux = post_reg[31:0];
      `IDX_POST + 16'h0001: rd_mux = post_reg[63:32];
      `IDX_ROUTE0: rd_mux = route0_reg;
      `IDX_ROUTE1: rd_mux = route1_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register writes land in the access phase; read data latched at setup
  always_comb begin
    mode_next = mode_reg;
    total_next = total_reg;
    seglen_next = seglen_reg;
    loops_next = loops_reg;
    post_next = post_reg;
    route0_next = route0_reg;
    route1_next = route1_reg;
    chen_next = chen_reg;
    prdata_next = (psel && !penable) ? rd_mux : prdata_reg;
    if (wr_acc) begin
      case (idx)
        `IDX_CTRL: chen_next = pwdata[`CTRL_CHEN_LSB +: 2];
        `IDX_MODE: mode_next = pwdata;
        `IDX_TOTAL: total_next[31:0] = pwdata;
        `IDX_TOTAL + 16'h0001: total_next[63:32] = pwdata;
        `IDX_SEGLEN: seglen_next[31:0] = pwdata;
        `IDX_SEGLEN + 16'h0001: seglen_next[63:32] = pwdata;
        `IDX_LOOPS: loops_next = pwdata;
        `IDX_POST: post_next[31:0] = pwdata;
        `IDX_POST + 16'h0001: post_next[63:32] = pwdata;
        `IDX_ROUTE0: route0_next = pwdata;
        `IDX_ROUTE1: route1_next = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 32'h0000_0000;
      total_reg <= 64'h0000_0000_0000_0000;
      seglen_reg <= 64'h0000_0000_0000_0000;
      loops_reg <= 32'h0000_0000;
      post_reg <= 64'h0000_0000_0000_0000;
      route0_reg <= 32'h0000_0000;
      route1_reg <= 32'h0000_0000;
      chen_reg <= `CHEN_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      mode_reg <= mode_next;
      total_reg <= total_next;
      seglen_reg <= seglen_next;
      loops_reg <= loops_next;
      post_reg <= post_next;
      route0_reg <= route0_next;
      route1_reg <= route1_next;
      chen_reg <= chen_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------------
  // Derived lengths; only the low word is used, memory is far smaller
  assign seglen = seglen_reg[31:0];
  assign post = post_reg[31:0];
  assign pre_len = seglen - post;
  assign cap_max = (chen_reg == 2'h3) ? `PRE_MAX_2CH : `PRE_MAX_1CH;
  assign mem_mode = (mode_reg == `MODE_MEM_SEG);
  assign stream_mode = (mode_reg == `MODE_STREAM_SEG);
  // A wrapped difference (post above length) also trips the cap
  assign cfg_err = (pre_len > cap_max) || (chen_reg == 2'h0) || (seglen == 32'h0000_0000) ||
                   (seglen > `MEM_WORDS) || !(mem_mode || stream_mode);
  assign wofs_inc = (wofs_reg + 32'h0000_0001 == seglen) ? 32'h0000_0000
                                                         : wofs_reg + 32'h0000_0001;
  assign seg_done = (cap_state == CAP_POST) && (post_cnt_reg == post);
  assign fmt0 = fmt_word(adc_ch0, mpio_in, route0_reg);
  assign fmt1 = fmt_word(adc_ch1, mpio_in, route1_reg);
  // Last segment: next region would pass the total count in memory mode, count reached in streaming
  assign last_seg = mem_mode ?
    ({20'h0_0000, base_reg} + seglen + seglen > total_reg[31:0]) :
    ((loops_reg != 32'h0000_0000) && (seg_cnt_reg + 32'h0000_0001 == loops_reg));
  assign mem_we = adc_valid && ((cap_state == CAP_PRE) ||
                  ((cap_state == CAP_POST) && !seg_done));
  assign mem_waddr = base_reg + wofs_reg[`MEM_AW-1:0];
  assign mem_wdata = {fmt1, fmt0};
  assign busy = (cap_state != CAP_IDLE);

  always_comb begin
    cap_state_next = cap_state;
    base_next = base_reg;
    wofs_next = wofs_reg;
    pre_fill_next = pre_fill_reg;
    post_cnt_next = post_cnt_reg;
    seg_cnt_next = seg_cnt_reg;
    rearm_next = rearm_reg;
    pre_err_next = pre_err_reg;
    case (cap_state)
      CAP_IDLE: begin
        if (start_req && cfg_err) begin
          pre_err_next = 1'b1;
        end else if (start_req) begin
          pre_err_next = 1'b0;
          cap_state_next = CAP_PRE;
          base_next = '0;
          wofs_next = 32'h0000_0000;
          pre_fill_next = 32'h0000_0000;
          seg_cnt_next = 32'h0000_0000;
        end
      end
      CAP_PRE: begin
        // Ring inside the segment region keeps the newest pre samples
        if (adc_valid) begin
          wofs_next = wofs_inc;
          if (pre_fill_reg < pre_len) begin
            pre_fill_next = pre_fill_reg + 32'h0000_0001;
          end
          // Trigger sample is the first post sample
          if (trig_in && (pre_fill_reg >= pre_len)) begin
            post_cnt_next = 32'h0000_0001;
            cap_state_next = CAP_POST;
          end
        end
      end
      CAP_POST: begin
        if (seg_done) begin
          seg_cnt_next = seg_cnt_reg + 32'h0000_0001;
          if (last_seg) begin
            cap_state_next = CAP_IDLE;
          end else begin
            // Streaming wraps to the start once the next region will not fit
            if (stream_mode && ({20'h0_0000, base_reg} + seglen + seglen > `MEM_WORDS)) begin
              base_next = '0;
            end else begin
              base_next = base_reg + seglen[`MEM_AW-1:0];
            end
            rearm_next = 4'(`REARM_CYCLES - 1);
            cap_state_next = CAP_REARM;
          end
        end else if (adc_valid) begin
          wofs_next = wofs_inc;
          post_cnt_next = post_cnt_reg + 32'h0000_0001;
        end
      end
      CAP_REARM: begin
        // Samples in this gap are dropped and never reach the host
        if (rearm_reg == 4'h0) begin
          cap_state_next = CAP_PRE;
          wofs_next = 32'h0000_0000;
          pre_fill_next = 32'h0000_0000;
        end else begin
          rearm_next = rearm_reg - 4'h1;
        end
      end
      default: cap_state_next = CAP_IDLE;
    endcase
    if (stop_req) begin
      cap_state_next = CAP_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_state <= CAP_IDLE;
      base_reg <= '0;
      wofs_reg <= 32'h0000_0000;
      pre_fill_reg <= 32'h0000_0000;
      post_cnt_reg <= 32'h0000_0000;
      seg_cnt_reg <= 32'h0000_0000;
      rearm_reg <= 4'h0;
      pre_err_reg <= 1'b0;
    end else begin
      cap_state <= cap_state_next;
      base_reg <= base_next;
      wofs_reg <= wofs_next;
      pre_fill_reg <= pre_fill_next;
      post_cnt_reg <= post_cnt_next;
      seg_cnt_reg <= seg_cnt_next;
      rearm_reg <= rearm_next;
      pre_err_reg <= pre_err_next;
    end
  end

  // Sample memory, one word holds both channels; read port is registered
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
    rd_data_reg <= mem[mem_raddr];
  end

  // ----------------------------------------------------------------------
  // Readout of finished segments
  // ----------------------------------------------------------------------
  // One pending slot; a new segment arriving while it is full replaces the pending one
  assign take = (rd_state == RD_IDLE) && pend_reg;
  assign first_phase = chen_reg[0] ? 2'h0 : 2'h2;
  assign last_phase = (phase_reg == 2'h3) || ((phase_reg == 2'h1) && !chen_reg[1]);
  assign mem_raddr = rd_base_reg + rd_ofs_reg[`MEM_AW-1:0];
  assign out_valid = out_valid_reg;
  assign out_byte = out_byte_reg;

  // Byte order within each 16-bit half of a word: upper byte first
  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] ph);
    logic [15:0] s;
    s = ph[1] ? w[31:16] : w[15:0];
    return ph[0] ? s[7:0] : s[15:8];
  endfunction : pick_byte

  always_comb begin
    pend_next = seg_done ? 1'b1 : (take ? 1'b0 : pend_reg);
    pend_base_next = seg_done ? base_reg : pend_base_reg;
    pend_start_next = seg_done ? wofs_reg : pend_start_reg;
    ovf_next = (start_req && !cfg_err) ? 1'b0 : ovf_reg;
    if (seg_done && pend_reg && !take) begin
      ovf_next = 1'b1;
    end
    rd_state_next = rd_state;
    rd_base_next = rd_base_reg;
    rd_ofs_next = rd_ofs_reg;
    rd_left_next = rd_left_reg;
    phase_next = phase_reg;
    out_valid_next = out_valid_reg;
    out_byte_next = out_byte_reg;
    case (rd_state)
      RD_IDLE: begin
        if (take) begin
          // Oldest sample sits where the ring pointer stopped
          rd_base_next = pend_base_reg;
          rd_ofs_next = pend_start_reg;
          rd_left_next = seglen;
          rd_state_next = RD_FETCH;
        end
      end
      RD_FETCH: rd_state_next = RD_LOAD;
      RD_LOAD: begin
        phase_next = first_phase;
        out_byte_next = pick_byte(rd_data_reg, first_phase);
        out_valid_next = 1'b1;
        rd_state_next = RD_EMIT;
      end
      RD_EMIT: begin
        if (out_ready) begin
          if (last_phase) begin
            out_valid_next = 1'b0;
            rd_ofs_next = (rd_ofs_reg + 32'h0000_0001 == seglen) ? 32'h0000_0000
                                                                 : rd_ofs_reg + 32'h0000_0001;
            rd_left_next = rd_left_reg - 32'h0000_0001;
            rd_state_next = (rd_left_reg == 32'h0000_0001) ? RD_IDLE : RD_FETCH;
          end else begin
            phase_next = (phase_reg == 2'h1) ? 2'h2 : phase_reg + 2'h1;
            out_byte_next = pick_byte(rd_data_reg, phase_next);
          end
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      pend_base_reg <= '0;
      pend_start_reg <= 32'h0000_0000;
      ovf_reg <= 1'b0;
      rd_state <= RD_IDLE;
      rd_base_reg <= '0;
      rd_ofs_reg <= 32'h0000_0000;
      rd_left_reg <= 32'h0000_0000;
      phase_reg <= 2'h0;
      out_valid_reg <= 1'b0;
      out_byte_reg <= 8'h00;
    end else begin
      pend_reg <= pend_next;
      pend_base_reg <= pend_base_next;
      pend_start_reg <= pend_start_next;
      ovf_reg <= ovf_next;
      rd_state <= rd_state_next;
      rd_base_reg <= rd_base_next;
      rd_ofs_reg <= rd_ofs_next;
      rd_left_reg <= rd_left_next;
      phase_reg <= phase_next;
      out_valid_reg <= out_valid_next;
      out_byte_reg <= out_byte_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rearm_wait;
    (cap_state == CAP_REARM) [*4];
  endsequence
  sequence s_rearmed;
    s_rearm_wait ##1 (cap_state == CAP_PRE);
  endsequence

  a_sign_extend: assert property (
    (route0_reg == 32'h0000_0000) |-> (fmt0[15:12] == {4{adc_ch0[`SIGN_BIT]}}))
    else $error("top bits are not a sign copy");
  // Lower three top bits of channel 1 stay unrouted, so they must carry the sign
  a_sign_partial: assert property (
    (route1_reg[`ROUTE_LSB0 +: 3 * `ROUTE_FLD_W] == 15'h0000) |->
      (fmt1[14:12] == {3{adc_ch1[`SIGN_BIT]}}))
    else $error("unrouted bits are not a sign copy");
  a_low_bits_pass: assert property (
    fmt1[11:0] == adc_ch1)
    else $error("converter bits altered");
  a_digital_lines: assert property (
    (route0_reg == `ROUTE_ALL_LINES) && mem_we |-> (mem_wdata[15:12] == mpio_in))
    else $error("digital lines misplaced");
  a_byte_order: assert property (
    (rd_state == RD_LOAD) && chen_reg[0] |=> out_valid && (out_byte == rd_data_reg[15:8]))
    else $error("upper byte not first");
  a_pre_error: assert property (
    (cap_state == CAP_IDLE) && start_req && cfg_err |=> pre_err_reg && (cap_state == CAP_IDLE))
    else $error("bad pre length accepted");
  // A stop during the gap legally cuts the wait short
  a_rearm_time: assert property (
    disable iff (!presetn || stop_req)
    seg_done && !last_seg && !stop_req |=> s_rearmed)
    else $error("re-arm interval wrong");
  a_post_count: assert property (
    (cap_state == CAP_POST) && $past(cap_state) == CAP_PRE |-> post_cnt_reg == 32'h0000_0001)
    else $error("trigger sample not counted");
  a_ring_bound: assert property (
    (cap_state == CAP_PRE) |-> (wofs_reg < seglen))
    else $error("ring pointer out of segment");
  a_loop_stop: assert property (
    seg_done && stream_mode && last_seg && !stop_req |=> (cap_state == CAP_IDLE) && !busy)
    else $error("streaming did not stop at count");
  a_mem_bound: assert property (
    mem_mode && busy |-> ({20'h0_0000, base_reg} + seglen <= total_reg[31:0]))
    else $error("segment beyond total count");
endmodule : segmented_adc_capture_format

// file: rtl/seg_capture_defines.svh
`ifndef SEG_CAPTURE_DEFINES_SVH
`define SEG_CAPTURE_DEFINES_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_CTRL 16'h0001
`define IDX_STATUS 16'h0002
`define IDX_SEG_DONE 16'h0003
`define IDX_MODE 16'h251C
`define IDX_TOTAL 16'h2710
`define IDX_SEGLEN 16'h271A
`define IDX_LOOPS 16'h2724
`define IDX_POST 16'h2774
`define IDX_ROUTE0 16'hB892
`define IDX_ROUTE1 16'hB893
// ----------------------------------------------------------------------
// Field values and layout
// ----------------------------------------------------------------------
`define MODE_MEM_SEG 32'h0000_0002
`define MODE_STREAM_SEG 32'h0000_0020
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_CHEN_LSB 4
`define CHEN_RESET 2'h1
`define ROUTE_LSB0 12
`define ROUTE_FLD_W 5
`define ROUTE_SRC_TAG 3'h1
`define ROUTE_ALL_LINES 32'h398A_4000
`define SIGN_BIT 11
// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define MEM_AW 12
`define MEM_WORDS 32'h0000_1000
`define PRE_MAX_1CH 32'h0000_8000
`define PRE_MAX_2CH 32'h0000_4000
`define REARM_TIME_NS 32
`define CLK_PERIOD_NS 8
`define REARM_CYCLES (`REARM_TIME_NS / `CLK_PERIOD_NS)
`endif

// file: rtl/seg_capture_pkg.sv
package seg_capture_pkg;
  // Capture sequencer states, one-hot
  typedef enum logic [3:0] {
    CAP_IDLE = 4'b0001,
    CAP_PRE = 4'b0010,
    CAP_POST = 4'b0100,
    CAP_REARM = 4'b1000
  } cap_state_e;
  // Readout sequencer states, one-hot
  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_FETCH = 4'b0010,
    RD_LOAD = 4'b0100,
    RD_EMIT = 4'b1000
  } rd_state_e;
  typedef logic [15:0] sample_word_t;
endpackage : seg_capture_pkg

// file: test/host_byte_sink.sv
`timescale 1ns/1ns
module host_byte_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  output logic out_ready
);
  int seed = 32835;
  logic [7:0] got[$];
  // Host side drains bytes with random stalls, so the source must hold each byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        got.push_back(out_byte);
      end
      out_ready <= ($random(seed) & 3) != 0;
    end
  end
endmodule : host_byte_sink

// file: test/tb.sv
`timescale 1ns/1ns
`include "seg_capture_defines.svh"
module tb;
  import seg_capture_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic adc_valid, trig_in, out_valid, out_ready, busy;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat, route0, route1;
  logic [11:0] adc_ch0, adc_ch1;
  logic [3:0] mpio_in;
  logic [7:0] out_byte;
  logic [1:0] chen;
  logic [7:0] exp_q[$];
  logic [31:0] modes[3] = '{`MODE_MEM_SEG, `MODE_STREAM_SEG, `MODE_STREAM_SEG};
  logic [31:0] loops_tab[3] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0000};
  logic [1:0] ch_tab[3] = '{2'h3, 2'h1, 2'h2};
  int nseg[3] = '{2, 3, 2};
  int seed = 32835;
  int num_errors = 0;
  int compares = 0;
  // Half-period toggle gives the 8 ns clock
  always #4 pclk = ~pclk;
  segmented_adc_capture_format u_segmented_adc_capture_format (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_ch0(adc_ch0), .adc_ch1(adc_ch1), .mpio_in(mpio_in),
    .trig_in(trig_in), .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready),
    .busy(busy));
  host_byte_sink u_host_byte_sink (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_byte(out_byte), .out_ready(out_ready));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] want, input string what);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  // Expected word: sign copy on top unless a field routes a line there
  function automatic sample_word_t fmt(input logic [11:0] a, input logic [3:0] l,
      input logic [31:0] r);
    sample_word_t w;
    logic [4:0] c;
    w = {{4{a[`SIGN_BIT]}}, a};
    for (int b = 0; b < 4; b++) begin
      c = r[`ROUTE_LSB0 + `ROUTE_FLD_W * b +: `ROUTE_FLD_W];
      if (c[4:2] == 3'h1) w[12 + b] = l[c[1:0]];
    end
    return w;
  endfunction : fmt
  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      chk(0, 1, "apb hang");
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_busy(input logic v);
    for (int n = 0; n < 300 && busy !== v; n++) @(negedge pclk);
    if (busy !== v) begin
      chk(0, 1, "busy hang");
      summarize();
    end
  endtask : wait_busy
  task cfg(input logic [31:0] mode, input logic [31:0] loops);
    apb(1, `IDX_MODE, mode);
    apb(1, `IDX_SEGLEN, 32'h0000_0008);
    apb(1, `IDX_POST, 32'h0000_0004);
    apb(1, `IDX_TOTAL, 32'h0000_0010);
    apb(1, `IDX_LOOPS, loops);
    apb(0, `IDX_MODE, 0);
    chk(rdat, mode, "mode readback");
    apb(1, `IDX_CTRL, {26'h0, chen, 4'h1});
  endtask : cfg
  // Random pre samples, trigger refused on the first and during post
  task automatic run_seg(input int extra);
    logic [11:0] h0[$], h1[$];
    logic [3:0] hl[$];
    sample_word_t w;
    for (int i = 0; i < extra + 8; i++) begin
      @(posedge pclk);
      h0.push_back(12'($random(seed)));
      h1.push_back(12'($random(seed)));
      hl.push_back(4'($random(seed)));
      adc_valid <= 1'b1;
      adc_ch0 <= h0[i];
      adc_ch1 <= h1[i];
      mpio_in <= hl[i];
      trig_in <= (i == 0) || (i >= extra + 4);
    end
    @(posedge pclk);
    adc_valid <= 1'b0;
    trig_in <= 1'b0;
    for (int i = extra; i < extra + 8; i++) begin
      w = fmt(h0[i], hl[i], route0);
      if (chen[0]) exp_q = {exp_q, w[15:8], w[7:0]};
      w = fmt(h1[i], hl[i], route1);
      if (chen[1]) exp_q = {exp_q, w[15:8], w[7:0]};
    end
    repeat (80) @(posedge pclk);
  endtask : run_seg
  task check_bytes;
    for (int n = 0; n < 2000 && u_host_byte_sink.got.size() < exp_q.size(); n++) begin
      @(negedge pclk);
    end
    chk(u_host_byte_sink.got.size(), exp_q.size(), "byte count");
    for (int i = 0; i < exp_q.size() && i < u_host_byte_sink.got.size(); i++) begin
      chk(u_host_byte_sink.got[i], exp_q[i], "segment byte");
    end
    exp_q.delete();
    u_host_byte_sink.got.delete();
  endtask : check_bytes
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, adc_valid, trig_in} = 5'h00;
    {paddr, pwdata, adc_ch0, adc_ch1, mpio_in} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `IDX_CTRL, 0);
    chk(rdat, {26'h0, `CHEN_RESET, 4'h0}, "ctrl reset");
    apb(0, 16'h0100, 0);
    chk({31'h0, rerr}, 1, "unmapped error");
    chk(rdat, 0, "unmapped data");
    route0 = `ROUTE_ALL_LINES;
    route1 = 32'hF800_0000 & 32'h294A_5000;
    apb(1, `IDX_ROUTE0, route0);
    apb(1, `IDX_ROUTE1, route1);
    // Memory mode, counted streaming, endless streaming ended by stop
    for (int k = 0; k < 3; k++) begin
      chen = ch_tab[k];
      cfg(modes[k], loops_tab[k]);
      wait_busy(1'b1);
      for (int s = 0; s < nseg[k]; s++) run_seg($random(seed) & 3);
      if (k == 2) begin
        chk({31'h0, busy}, 1, "endless run ended early");
        apb(1, `IDX_CTRL, {26'h0, chen, 4'h2});
      end
      wait_busy(1'b0);
      apb(0, `IDX_SEG_DONE, 0);
      chk(rdat, nseg[k], "segments done");
      check_bytes();
    end
    chen = 2'h3;
    cfg(32'h0000_0005, 0);
    repeat (4) @(posedge pclk);
    chk({31'h0, busy}, 0, "bad mode started");
    apb(0, `IDX_STATUS, 0);
    chk({31'h0, rdat[8]}, 1, "config error flag");
    // Good start clears the flag; post above length wraps the pre count past the cap
    cfg(`MODE_MEM_SEG, 0);
    apb(1, `IDX_CTRL, {26'h0, chen, 4'h2});
    apb(0, `IDX_STATUS, 0);
    chk({31'h0, rdat[8]}, 0, "error flag not cleared");
    apb(1, `IDX_POST, 32'h0000_0009);
    apb(1, `IDX_CTRL, {26'h0, chen, 4'h1});
    repeat (4) @(posedge pclk);
    chk({31'h0, busy}, 0, "long pre started");
    apb(0, `IDX_STATUS, 0);
    chk({31'h0, rdat[8]}, 1, "pre length error");
    summarize();
  end
endmodule : tb
